// [srsr_pkg.sv]
// srsr_pkg: constants for the status reporting and service request block
// assumes: imported by srsr_status.sv, no other dependencies
package srsr_pkg;
   // status byte bit positions
   localparam int SB_QUES_BIT = 3;
   localparam int SB_MSG_BIT  = 4;
   localparam int SB_STD_BIT  = 5;
   localparam int SB_RQS_BIT  = 6;
   // standard event bit positions
   localparam int SE_OPC_BIT  = 0;
   localparam int SE_QRY_BIT  = 2;
   localparam int SE_DEV_BIT  = 3;
   localparam int SE_EXE_BIT  = 4;
   localparam int SE_CMD_BIT  = 5;
   localparam int SE_PON_BIT  = 7;
   // masks of the used bits; the bits outside them always read as zero
   localparam logic [7:0] SB_USED_MASK = 8'h78;
   localparam logic [7:0] SE_USED_MASK = 8'hbd;
   // reset values
   localparam logic [7:0]  SE_EVENT_RESET = 8'h80;
   localparam logic [7:0]  MASK_RESET     = 8'h00;
   localparam logic [15:0] QUES_RESET     = 16'h0000;
   // error queue sizing
   localparam int ERRQ_DEPTH = 20;
   localparam int ERRQ_CHARS = 80;
   // self-test answers
   localparam logic [7:0] TEST_PASS = 8'h00;
   localparam logic [7:0] TEST_FAIL = 8'h01;
   // query selector codes
   typedef enum logic [2:0] {
      SRSR_Q_STB,
      SRSR_Q_ESR,
      SRSR_Q_ESE,
      SRSR_Q_QEVENT,
      SRSR_Q_QENABLE,
      SRSR_Q_SRV_MASK,
      SRSR_Q_TEST
   } srsr_query_t;
endpackage

// [srsr_status.sv]
// srsr_status: status byte, event/enable register groups, service request,
// error queue, self-test answer and configuration reset for the remote port.
// assumes: the command parser gives one-cycle strobes on i_clock, finishes earlier
// commands before strobing a status-byte query, and handles text of error entries.
// Summary of operation
// - event bits latch on condition and stay set until cleared
// - event query clears its register; clear-status clears all event registers
// - instrument reset and device clear leave event registers alone
// - queries return binary weighted sum: bit n weighs two to the n
// - group summary is OR of event bits gated by enable bits
// - enable registers writable and readable; reading leaves them intact
// - clear-status leaves enable registers untouched
// - status preset zeroes the questionable data enable register
// - status byte: bit3 ques, bit4 message, bit5 std, bit6 rqs, rest zero
// - message bit set while output data waits, clear once all read
// - summary bits follow their sources without latching
// - clear-status clears summary; event query clears only its group summary
// - service mask zeroed by write of zero; power-on clear per setting
// - service mask selects summaries for bit 6; bit 6 drives bus request
// - request service cleared only by serial poll, causing event read or clear-status
// - serial poll returns byte then clears only request service bit, when no masked summary is still set
// - status-byte query after earlier commands, clears nothing
// - error queue keeps 20 entry codes, FIFO order; the parser keeps text of up to 80 chars
// - self-test query returns 0 on pass, 1 on fail
// - reset command restores configuration to power-on state
// - beeper enable nonvolatile; disabled means no event tones
// - std event: opc0 qry2 dev3 exe4 cmd5 pon7, bits 1 and 6 zero
`timescale 1ns/1ns
`default_nettype none
module srsr_status
   import srsr_pkg::*;
#(
   parameter int QW  = 16,
   parameter int EW  = 16,
   parameter int EQD = ERRQ_DEPTH
)
(
   input  wire logic          i_clock,
   input  wire logic          i_reset_n,
   input  wire logic          i_enable,
   input  wire logic [7:0]    i_std_event,
   input  wire logic [QW-1:0] i_ques_event,
   input  wire logic          i_out_buf_nonempty,
   input  wire logic          i_clear_status,
   input  wire logic          i_status_preset,
   input  wire logic          i_instr_reset,
   input  wire logic          i_device_clear,
   input  wire logic          i_serial_poll,
   input  wire logic          i_query,
   input  wire logic [2:0]    i_query_sel,
   input  wire logic          i_write_ese,
   input  wire logic          i_write_ques_en,
   input  wire logic          i_write_srv_mask,
   input  wire logic [15:0]   i_write_data,
   input  wire logic          i_power_on_clear,
   input  wire logic          i_beep_nv,
   input  wire logic          i_beep_set,
   input  wire logic          i_beep_value,
   input  wire logic          i_beep_request,
   input  wire logic          i_self_test_done,
   input  wire logic          i_self_test_fail,
   input  wire logic          i_err_push,
   input  wire logic [EW-1:0] i_err_code,
   input  wire logic          i_err_pop,
   output logic [7:0]         o_poll_byte,
   output logic               o_poll_valid,
   output logic [15:0]        o_query_data,
   output logic               o_query_valid,
   output logic               o_service_request,
   output logic [EW-1:0]      o_err_code,
   output logic               o_err_valid,
   output logic               o_err_overflow,
   output logic               o_beep_enable,
   output logic               o_beep_tone,
   output logic               o_config_reset
);
   initial
   begin
      if (QW < 1 || QW > 16 || EW < 1 || EQD < 2 || EQD > 255)
      begin
         $error("srsr_status: unsupported parameter values");
      end
   end

   localparam int PW = $clog2(EQD);
   localparam logic [PW-1:0] PLAST = PW'(EQD - 1);
   localparam logic [PW:0]   CFULL = (PW+1)'(EQD);

   logic [7:0]    std_ff;
   logic [7:0]    ese_ff;
   logic [QW-1:0] ques_ff;
   logic [QW-1:0] ques_en_ff;
   logic [7:0]    service_request_mask_ff;
   logic          rqs_ff;
   logic          msg_s1_ff;
   logic          message_waiting_flag_ff;
   logic [EW-1:0] errq_ff [EQD];
   logic [PW-1:0] rd_ptr_ff;
   logic [PW-1:0] wr_ptr_ff;
   logic [PW:0]   count_ff;
   logic          beep_ff;
   logic [7:0]    test_ff;
   logic          pon_seen_ff;

   // query decode
   wire q_esr  = i_query && (i_query_sel == 3'(SRSR_Q_ESR));
   wire q_ques = i_query && (i_query_sel == 3'(SRSR_Q_QEVENT));
   wire q_stb  = i_query && (i_query_sel == 3'(SRSR_Q_STB));

   // group summaries straight from registers, no pipeline
   wire std_sum  = |(std_ff & ese_ff);
   wire ques_sum = |(ques_ff & ques_en_ff);

   wire [7:0] summary_bits;
   assign summary_bits[SB_QUES_BIT] = ques_sum;
   assign summary_bits[SB_MSG_BIT]  = message_waiting_flag_ff;
   assign summary_bits[SB_STD_BIT]  = std_sum;
   assign summary_bits[SB_RQS_BIT]  = 1'b0;
   assign summary_bits[2:0]         = 3'b000;
   assign summary_bits[7]           = 1'b0;

   // a summary being cleared this cycle must not re-raise the request it caused
   wire [7:0] sum_clr = {2'b00, q_esr || i_clear_status, 1'b0, q_ques || i_clear_status, 3'b000};
   // a masked summary raises the request; it sets bit 6 every cycle it holds
   wire rqs_cause = |(summary_bits & ~sum_clr & service_request_mask_ff & SB_USED_MASK);

   wire [7:0] status_byte = (summary_bits | ({7'h00, rqs_ff} << SB_RQS_BIT)) & SB_USED_MASK;

   // clearing the group that caused the request drops it as well
   wire rqs_event_clr = (q_esr && service_request_mask_ff[SB_STD_BIT])
                     || (q_ques && service_request_mask_ff[SB_QUES_BIT]);
   wire nxt_rqs = rqs_cause || (rqs_ff && !i_serial_poll && !rqs_event_clr
                               && !i_clear_status);

   // event latches: set wins over clear in the same cycle
   wire [7:0] std_set = i_std_event & SE_USED_MASK;
   wire [7:0] nxt_std = ((q_esr || i_clear_status) ? 8'h00 : std_ff) | std_set;
   wire [QW-1:0] nxt_ques = ((q_ques || i_clear_status) ? '0 : ques_ff) | i_ques_event;

   wire errq_push = i_err_push && (count_ff != CFULL);
   wire errq_pop  = i_err_pop && (count_ff != '0);

   logic [15:0] query_mux;
   always_comb
   begin
      case (i_query_sel)
         3'(SRSR_Q_STB):     query_mux = {8'h00, status_byte};
         3'(SRSR_Q_ESR):     query_mux = {8'h00, std_ff};
         3'(SRSR_Q_ESE):     query_mux = {8'h00, ese_ff};
         3'(SRSR_Q_QEVENT):  query_mux = 16'(ques_ff);
         3'(SRSR_Q_QENABLE): query_mux = 16'(ques_en_ff);
         3'(SRSR_Q_SRV_MASK): query_mux = {8'h00, service_request_mask_ff};
         3'(SRSR_Q_TEST):    query_mux = {8'h00, test_ff};
         default:            query_mux = 16'h0000;
      endcase
   end

   // event and enable registers
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         std_ff     <= SE_EVENT_RESET;
         ques_ff    <= QW'(QUES_RESET);
         ese_ff     <= MASK_RESET;
         ques_en_ff <= QW'(QUES_RESET);
         rqs_ff     <= 1'b0;
      end
      else if (i_enable)
      begin
         std_ff  <= nxt_std;
         ques_ff <= nxt_ques;
         rqs_ff  <= nxt_rqs;
         // enable writes, status preset and power-on clear only; clear-status never touches them
         if (i_write_ese)
         begin
            ese_ff <= i_write_data[7:0] & SE_USED_MASK;
         end
         else if (pon_seen_ff && i_power_on_clear)
         begin
            ese_ff <= MASK_RESET;
         end
         if (i_status_preset)
         begin
            ques_en_ff <= QW'(QUES_RESET);
         end
         else if (i_write_ques_en)
         begin
            ques_en_ff <= i_write_data[QW-1:0];
         end
      end
   end

   // marks the first enabled cycle after power-on
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         pon_seen_ff <= 1'b1;
      end
      else if (i_enable)
      begin
         pon_seen_ff <= 1'b0;
      end
   end

   // mask has no reset so it survives power-on when the clear setting is off;
   // limitation: a cold start with the setting off leaves it unknown until written
   always_ff @(posedge i_clock)
   begin
      if (i_enable && i_write_srv_mask)
      begin
         service_request_mask_ff <= i_write_data[7:0] & SB_USED_MASK & ~8'h40;
      end
      else if (i_enable && pon_seen_ff && i_power_on_clear)
      begin
         service_request_mask_ff <= MASK_RESET;
      end
   end

   // message available comes from the output buffer logic, possibly async
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         msg_s1_ff               <= 1'b0;
         message_waiting_flag_ff <= 1'b0;
      end
      else if (i_enable)
      begin
         msg_s1_ff               <= i_out_buf_nonempty;
         message_waiting_flag_ff <= msg_s1_ff;
      end
   end

   // answers to the bus and to the parser
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_poll_byte       <= 8'h00;
         o_poll_valid      <= 1'b0;
         o_query_data      <= 16'h0000;
         o_query_valid     <= 1'b0;
         o_service_request <= 1'b0;
      end
      else if (i_enable)
      begin
         o_poll_valid      <= i_serial_poll;
         o_query_valid     <= i_query;
         o_service_request <= nxt_rqs;
         if (i_serial_poll)
         begin
            o_poll_byte <= status_byte;
         end
         if (i_query)
         begin
            o_query_data <= q_stb ? {8'h00, status_byte} : query_mux;
         end
      end
   end

   // error queue of codes; the parser keeps each entry's text of up to 80 chars
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rd_ptr_ff      <= '0;
         wr_ptr_ff      <= '0;
         count_ff       <= '0;
         o_err_overflow <= 1'b0;
      end
      else if (i_enable)
      begin
         if (errq_push)
         begin
            wr_ptr_ff <= (wr_ptr_ff == PLAST) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (errq_pop)
         begin
            rd_ptr_ff <= (rd_ptr_ff == PLAST) ? '0 : rd_ptr_ff + 1'b1;
         end
         count_ff <= count_ff + (PW+1)'(errq_push) - (PW+1)'(errq_pop);
         if (i_err_push && !errq_push)
         begin
            o_err_overflow <= 1'b1;
         end
         else if (i_clear_status)
         begin
            o_err_overflow <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_enable && errq_push)
      begin
         errq_ff[wr_ptr_ff] <= i_err_code;
      end
   end

   // head of queue registered so the output stays flop driven
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_err_code  <= '0;
         o_err_valid <= 1'b0;
      end
      else if (i_enable)
      begin
         o_err_valid <= (count_ff != '0);
         o_err_code  <= (count_ff != '0) ? errq_ff[rd_ptr_ff] : '0;
      end
   end

   // self-test result, beeper and configuration reset
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         test_ff        <= TEST_PASS;
         beep_ff        <= 1'b1;
         o_beep_enable  <= 1'b1;
         o_beep_tone    <= 1'b0;
         o_config_reset <= 1'b1;
      end
      else if (i_enable)
      begin
         if (i_self_test_done)
         begin
            test_ff <= i_self_test_fail ? TEST_FAIL : TEST_PASS;
         end
         // beeper state lives in the nonvolatile store; reload it at power-on
         if (i_beep_set)
         begin
            beep_ff <= i_beep_value;
         end
         else if (pon_seen_ff)
         begin
            beep_ff <= i_beep_nv;
         end
         o_beep_enable  <= i_beep_set ? i_beep_value : beep_ff;
         o_beep_tone    <= i_beep_request && beep_ff;
         // pulse tells config logic to reload power-on state; events stay intact
         o_config_reset <= pon_seen_ff || i_instr_reset;
      end
   end
endmodule
`default_nettype wire

// [srsr_status_checker.sv]
// srsr_status_checker: port-level assertions for srsr_status
// assumes: bound into srsr_status, port names match the design's ports
`timescale 1ns/1ns
`default_nettype none
module srsr_status_checker
   import srsr_pkg::*;
#(
   parameter int EW = 16
)
(
   input wire logic          i_clock,
   input wire logic          i_reset_n,
   input wire logic          i_enable,
   input wire logic          i_query,
   input wire logic [2:0]    i_query_sel,
   input wire logic          i_serial_poll,
   input wire logic          i_clear_status,
   input wire logic          i_instr_reset,
   input wire logic          i_err_push,
   input wire logic          i_err_pop,
   input wire logic [EW-1:0] i_err_code,
   input wire logic [7:0]    o_poll_byte,
   input wire logic          o_poll_valid,
   input wire logic [15:0]   o_query_data,
   input wire logic          o_query_valid,
   input wire logic          o_service_request,
   input wire logic [EW-1:0] o_err_code,
   input wire logic          o_err_valid,
   input wire logic          o_err_overflow,
   input wire logic          o_config_reset
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   query_answer_a: assert property (i_enable && i_query |=> o_query_valid)
      else $error("query not answered");
   poll_answer_a: assert property (i_enable && i_serial_poll |=> o_poll_valid)
      else $error("poll not answered");
   poll_byte_zero_a: assert property (o_poll_valid |-> (o_poll_byte & ~SB_USED_MASK) == 8'h00)
      else $error("poll byte unused bit set");
   stb_zero_bits_a: assert property (o_query_valid && $past(i_query_sel) == SRSR_Q_STB |->
      (o_query_data & 16'hff87) == 16'h0000) else $error("status byte unused bit set");
   std_zero_bits_a: assert property (o_query_valid && $past(i_query_sel) == SRSR_Q_ESR |->
      (o_query_data & 16'hff42) == 16'h0000) else $error("std event unused bit set");
   test_answer_a: assert property (o_query_valid && $past(i_query_sel) == SRSR_Q_TEST |->
      o_query_data inside {16'h0000, 16'h0001}) else $error("self-test answer out of range");
   stb_keeps_rqs_a: assert property (i_enable && i_query && i_query_sel == SRSR_Q_STB && o_service_request
      && !i_serial_poll && !i_clear_status && $past(!i_serial_poll && !i_clear_status && !i_query)
      |=> o_service_request) else $error("status query dropped service request");
   err_head_a: assert property (i_enable && i_err_push && !i_err_pop && !o_err_valid && $past(!i_err_push)
      ##1 (i_enable && !i_err_pop) |=> o_err_valid && o_err_code == $past(i_err_code, 2))
      else $error("error entry not at head");
   overflow_sticky_a: assert property (o_err_overflow && !i_clear_status |=> o_err_overflow)
      else $error("overflow flag lost");
   config_reset_a: assert property (i_enable && i_instr_reset |=> o_config_reset)
      else $error("reset command not passed on");
endmodule
bind srsr_status srsr_status_checker #(.EW(EW)) u_chk (.*);
`default_nettype wire

// [srsr_ctrl_model.sv]
// srsr_ctrl_model: bus controller that serial-polls when service is requested
// assumes: drives i_serial_poll of one srsr_status on the same clock
`timescale 1ns/1ns
`default_nettype none
module srsr_ctrl_model
(
   input  wire logic       i_clock,
   input  wire logic       i_auto,
   input  wire logic [3:0] i_lag,
   input  wire logic       i_srq,
   input  wire logic [7:0] i_poll_byte,
   output logic            o_poll,
   output logic [7:0]      o_byte,
   output int              o_polls
);
   initial
   begin
      o_poll = 1'b0;
      o_byte = 8'h00;
      o_polls = 0;
      forever
      begin
         @(negedge i_clock);
         if (i_auto && i_srq)
         begin
            repeat (i_lag) @(negedge i_clock);
            o_poll = 1'b1;
            @(negedge i_clock);
            o_poll = 1'b0;
            o_byte = i_poll_byte;
            o_polls++;
            // hold off so a request line still settling is not polled twice
            repeat (3) @(negedge i_clock);
         end
      end
   end
endmodule
`default_nettype wire

// [tb_status_reporting_service_request.sv]
// tb_status_reporting_service_request: self-checking bench for srsr_status
// assumes: srsr_status, srsr_ctrl_model and the bound checker compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_status_reporting_service_request;
   import srsr_pkg::*;
   logic i_clock, i_reset_n, i_enable, i_out_buf_nonempty, i_clear_status, i_status_preset, i_instr_reset;
   logic i_device_clear, i_serial_poll, i_query, i_write_ese, i_write_ques_en, i_write_srv_mask, i_power_on_clear;
   logic i_beep_nv, i_beep_set, i_beep_value, i_beep_request, i_self_test_done, i_self_test_fail, i_err_push, i_err_pop;
   logic o_poll_valid, o_query_valid, o_service_request, o_err_valid, o_err_overflow, o_beep_enable, o_beep_tone;
   logic o_config_reset, auto;
   logic [7:0] i_std_event, o_poll_byte, pbyte, e, m;
   logic [15:0] i_ques_event, i_write_data, i_err_code, o_query_data, o_err_code, q, qm;
   logic [15:0] codes [0:20];
   logic [2:0] i_query_sel;
   logic [3:0] lag;
   int err_count, checks_done, cycles, polls;
   srsr_status dut (.*);
   srsr_ctrl_model ctrl (.i_clock(i_clock), .i_auto(auto), .i_lag(lag), .i_srq(o_service_request),
      .i_poll_byte(o_poll_byte), .o_poll(i_serial_poll), .o_byte(pbyte), .o_polls(polls));
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input string n, input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge i_clock);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask
   task automatic wr(ref logic s, input logic [15:0] v);
      i_write_data = v;
      pulse(s);
   endtask
   task automatic qchk(input string n, input logic [2:0] s, input logic [15:0] exp);
      i_query_sel = s;
      pulse(i_query);
      check("query_valid", {15'h0000, o_query_valid}, 16'h0001);
      check(n, o_query_data, exp);
      // one clock edge between queries so the strobe is never lowered and raised at once
      tick(1);
      check("query_done", {15'h0000, o_query_valid}, 16'h0000);
   endtask
   // status byte as the bench expects it from event, enable and flag state
   function automatic logic [15:0] stb(input logic [7:0] se, input logic [7:0] en, input logic [15:0] qe,
      input logic [15:0] qen, input logic msg, input logic rqs);
      return {9'h000, rqs, |(se & en & SE_USED_MASK), msg, |(qe & qen), 3'b000};
   endfunction
   initial
   begin
      i_clock = 1'b0;
      forever #4 i_clock = ~i_clock;
   end
   always @(posedge i_clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         print_verdict();
      end
   end
   initial
   begin
      {i_reset_n, i_out_buf_nonempty, i_clear_status, i_status_preset, i_instr_reset, i_device_clear} = '0;
      {i_query, i_write_ese, i_write_ques_en, i_write_srv_mask, i_beep_set, i_beep_value, i_beep_request} = '0;
      {i_self_test_done, i_self_test_fail, i_err_push, i_err_pop, auto, lag, i_query_sel} = '0;
      {i_std_event, i_ques_event, i_write_data, i_err_code} = '0;
      {i_enable, i_power_on_clear, i_beep_nv} = 3'b111;
      void'($urandom(32'h09134a5d));
      tick(12);
      i_reset_n = 1'b1;
      tick(1);
      qchk("esr_pon", SRSR_Q_ESR, 16'h0080);
      qchk("esr_cleared", SRSR_Q_ESR, 16'h0000);
      qchk("mask_pon", SRSR_Q_SRV_MASK, 16'h0000);
      for (int i = 0; i < 8; i++)
      begin
         e = 8'($urandom) & SE_USED_MASK;
         m = (i < 2) ? {8{i[0]}} & SE_USED_MASK : 8'($urandom) & SE_USED_MASK;
         q = 16'($urandom);
         qm = 16'($urandom);
         wr(i_write_ese, {8'h00, m});
         wr(i_write_ques_en, qm);
         i_std_event = e;
         i_ques_event = q;
         tick(1);
         i_std_event = 8'h00;
         i_ques_event = 16'h0000;
         tick(1);
         qchk("stb", SRSR_Q_STB, stb(e, m, q, qm, 1'b0, 1'b0));
         qchk("ese_read", SRSR_Q_ESE, {8'h00, m});
         qchk("ese_reread", SRSR_Q_ESE, {8'h00, m});
         qchk("qen_read", SRSR_Q_QENABLE, qm);
         if (i[0])
         begin
            pulse(i_clear_status);
            qchk("ques_after_cls", SRSR_Q_QEVENT, 16'h0000);
            qchk("ese_after_cls", SRSR_Q_ESE, {8'h00, m});
            e = 8'h00;
         end
         else
         begin
            qchk("ques_event", SRSR_Q_QEVENT, q);
            qchk("stb_ques_gone", SRSR_Q_STB, stb(e, m, 16'h0000, qm, 1'b0, 1'b0));
         end
         check("config_idle", {15'h0000, o_config_reset}, 16'h0000);
         pulse(i_instr_reset);
         check("config_reset", {15'h0000, o_config_reset}, 16'h0001);
         pulse(i_device_clear);
         qchk("esr_kept", SRSR_Q_ESR, {8'h00, e});
         qchk("stb_std_gone", SRSR_Q_STB, 16'h0000);
      end
      wr(i_write_ques_en, 16'hffff);
      pulse(i_status_preset);
      qchk("qen_preset", SRSR_Q_QENABLE, 16'h0000);
      wr(i_write_ese, 16'h0001);
      wr(i_write_srv_mask, 16'h0020);
      qchk("mask_read", SRSR_Q_SRV_MASK, 16'h0020);
      i_std_event = 8'h01;
      tick(1);
      i_std_event = 8'h00;
      tick(3);
      check("srq_up", {15'h0000, o_service_request}, 16'h0001);
      qchk("stb_rqs", SRSR_Q_STB, 16'h0060);
      for (int k = 0; k < 2; k++)
      begin
         lag = 4'($urandom);
         auto = 1'b1;
         for (int w = 0; w < 40 && polls == k; w++)
            tick(1);
         auto = 1'b0;
         check("poll_byte", {8'h00, pbyte}, 16'h0060);
         check("poll_count", 16'(polls), 16'(k + 1));
         tick(2);
         qchk("stb_after_poll", SRSR_Q_STB, {9'h000, k == 0, 6'h20});
         if (k == 0)
            wr(i_write_srv_mask, 16'h0000);
         qchk("mask_zero", SRSR_Q_SRV_MASK, 16'h0000);
      end
      check("srq_polled_off", {15'h0000, o_service_request}, 16'h0000);
      wr(i_write_srv_mask, 16'h0020);
      tick(3);
      check("srq_again", {15'h0000, o_service_request}, 16'h0001);
      qchk("esr_opc", SRSR_Q_ESR, 16'h0001);
      tick(3);
      check("srq_read_off", {15'h0000, o_service_request}, 16'h0000);
      i_out_buf_nonempty = 1'b1;
      tick(3);
      qchk("msg_set", SRSR_Q_STB, 16'h0010);
      i_out_buf_nonempty = 1'b0;
      tick(3);
      qchk("msg_clear", SRSR_Q_STB, 16'h0000);
      // second power-on with the clear setting off: the service mask must survive
      i_power_on_clear = 1'b0;
      i_reset_n = 1'b0;
      tick(2);
      i_reset_n = 1'b1;
      tick(1);
      qchk("mask_kept", SRSR_Q_SRV_MASK, 16'h0020);
      check("srq_after_reset", {15'h0000, o_service_request}, 16'h0000);
      // enable low freezes the event latch
      i_enable = 1'b0;
      i_std_event = 8'h20;
      tick(2);
      i_std_event = 8'h00;
      i_enable = 1'b1;
      qchk("esr_frozen", SRSR_Q_ESR, 16'h0080);
      i_err_push = 1'b1;
      for (int k = 0; k <= ERRQ_DEPTH; k++)
      begin
         codes[k] = 16'($urandom);
         i_err_code = codes[k];
         tick(1);
      end
      i_err_push = 1'b0;
      tick(2);
      check("overflow", {15'h0000, o_err_overflow}, 16'h0001);
      for (int k = 0; k < ERRQ_DEPTH; k++)
      begin
         check("err_head", o_err_code, codes[k]);
         pulse(i_err_pop);
         tick(2);
      end
      check("err_empty", {15'h0000, o_err_valid}, 16'h0000);
      for (int k = 0; k < 2; k++)
      begin
         i_self_test_fail = k[0];
         pulse(i_self_test_done);
         qchk("self_test", SRSR_Q_TEST, {15'h0000, k[0]});
      end
      pulse(i_beep_set);
      i_beep_request = 1'b1;
      tick(4);
      check("beep_off", {14'h0000, o_beep_enable, o_beep_tone}, 16'h0000);
      i_beep_value = 1'b1;
      pulse(i_beep_set);
      tick(1);
      check("beep_on", {14'h0000, o_beep_enable, o_beep_tone}, 16'h0003);
      print_verdict();
   end
endmodule
`default_nettype wire
